// ===== hdl/axis_position_compare_unit.sv
// Axis position tracking, compare, jog and interrupt logic with a bus.
`timescale 1ns/1ps
`include "axis_cmp_defs.svh"
module axis_position_compare_unit #(
    parameter int CLK_HZ = 20000000 // System clock rate
) (
    input  wire logic                    clk_i,      // System clock
    input  wire logic                    rst_i,      // Sync reset
    input  wire logic                    wb_cyc_i,   // Bus cycle
    input  wire logic                    wb_stb_i,   // Bus strobe
    input  wire logic                    wb_we_i,    // Write
    input  wire logic [7:0]              wb_adr_i,   // Byte address
    input  wire logic [3:0]              wb_sel_i,   // Byte lanes
    input  wire logic [31:0]             wb_dat_i,   // Write data
    output logic [31:0]                  wb_dat_o,   // Read data
    output logic                         wb_ack_o,   // Acknowledge
    input  wire axis_cmp_pkg::enc_pins_s enc_i,      // Encoder pins
    input  wire axis_cmp_pkg::jog_pins_s jog_i,      // Jog pins
    input  wire axis_cmp_pkg::spd_e      spd_i,      // Profile phase
    input  wire logic                    gen_pulse_i, // Generator pulse
    input  wire logic                    gen_dir_i,  // Generator dir
    input  wire logic                    gen_busy_i, // Move in progress
    output logic                         pulse_o,    // Output pulse
    output logic                         dir_o,      // Output dir
    output logic                         lim_plus_o, // Soft limit +
    output logic                         lim_minus_o, // Soft limit -
    output logic                         irq_o       // Interrupt
);
    import axis_cmp_pkg::*;

    localparam int PULSE_CYC = (`PULSE_PERIOD_NS * (CLK_HZ / 1000000)
                                + 999) / 1000;

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    logic [31:0] ctrl_q, ctrl_d, en_q, en_d, up_q, up_d, lo_q, lo_d;
    logic [31:0] jcnt_q, jcnt_d;
    logic [6:0]  stat_q, stat_d, ev;
    logic signed [31:0] cmd_q, cmd_d, act_q, act_d;
    logic [31:0] rdat_d;
    logic        ack_d;
    logic        enc_step, enc_dir;
    logic        wr, rd_go;
    logic        gen_busy_q, sel_ge_lo_q, sel_ge_up_q;
    spd_e        spd_q;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    enc_decoder u_dec (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .updn_i (ctrl_q[`CTRL_ENC_MODE]),
        .mult_i (mult_e'(ctrl_q[`CTRL_MULT_LSB +: 2])),
        .pins_i (enc_i),
        .step_o (enc_step),
        .dir_o  (enc_dir)
    );

    // --------------------------------------------------------------
    // Jog and pulse source
    // --------------------------------------------------------------
    jog_state_e js_q, js_d;
    logic [31:0] left_q, left_d;
    logic [15:0] tick_q, tick_d;
    logic        jp_q, jm_q, jdir_q, jdir_d;
    logic        pulse_d, pdir_d, want;
    logic        lim_p, lim_m;
    logic signed [31:0] sel_pos;

    assign sel_pos = ctrl_q[`CTRL_CMP_SEL] ? act_q : cmd_q;
    // Reaching the upper bound or crossing the lower one blocks further motion that way.
    assign lim_p = ctrl_q[`CTRL_SWLIM_EN] && (sel_pos >= $signed(up_q));
    assign lim_m = ctrl_q[`CTRL_SWLIM_EN] && (sel_pos <  $signed(lo_q));

    always_comb begin
        js_d    = js_q;
        left_d  = left_q;
        tick_d  = (tick_q == 16'h0000) ? 16'h0000 : tick_q - 16'h0001;
        jdir_d  = jdir_q;
        pulse_d = 1'b0;
        pdir_d  = dir_o;
        want    = 1'b0;
        if (gen_pulse_i && !(gen_dir_i ? lim_p : lim_m)) begin
            pulse_d = 1'b1;
            pdir_d  = gen_dir_i;
        end else if (ctrl_q[`CTRL_JOG_EN]) begin
            if (ctrl_q[`CTRL_HANDWHEEL]) begin
                // Handwheel: each rising edge is one pulse that way.
                if (jog_i.plus && !jp_q && !lim_p) begin
                    pulse_d = 1'b1;
                    pdir_d  = 1'b1;
                end else if (jog_i.minus && !jm_q && !lim_m) begin
                    pulse_d = 1'b1;
                    pdir_d  = 1'b0;
                end
            end else begin
                case (js_q)
                    JOG_IDLE: begin
                        if ((jog_i.plus && !jp_q) ||
                            (jog_i.minus && !jm_q)) begin
                            js_d   = JOG_RUN;
                            jdir_d = jog_i.plus;
                            left_d = jcnt_q;
                        end
                    end
                    JOG_RUN: begin
                        want = ctrl_q[`CTRL_JOG_FIXED] ? (left_q != 32'h0)
                             : (jdir_q ? jog_i.plus : jog_i.minus);
                        if (!want) begin
                            js_d = JOG_WAIT;
                        end else if (tick_q == 16'h0000 &&
                                     !(jdir_q ? lim_p : lim_m)) begin
                            pulse_d = 1'b1;
                            pdir_d  = jdir_q;
                            tick_d  = 16'(PULSE_CYC - 1);
                            left_d  = left_q - 32'h1;
                        end
                    end
                    JOG_WAIT: begin
                        if (!jog_i.plus && !jog_i.minus) begin
                            js_d = JOG_IDLE;
                        end
                    end
                    default: js_d = JOG_IDLE;
                endcase
            end
        end
    end

    // --------------------------------------------------------------
    // Counters, compare events and bus
    // --------------------------------------------------------------
    assign wr    = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign rd_go = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_comb begin
        cmd_d  = cmd_q;
        act_d  = act_q;
        if (pulse_o) begin
            cmd_d = dir_o ? cmd_q + 32'sd1 : cmd_q - 32'sd1;
        end
        if (enc_step) begin
            act_d = enc_dir ? act_q + 32'sd1 : act_q - 32'sd1;
        end
        ev = 7'h00;
        ev[`EV_GE_LO] = (sel_pos >= $signed(lo_q)) && !sel_ge_lo_q;
        ev[`EV_LT_LO] = (sel_pos <  $signed(lo_q)) &&  sel_ge_lo_q;
        ev[`EV_LT_UP] = (sel_pos <  $signed(up_q)) &&  sel_ge_up_q;
        ev[`EV_GE_UP] = (sel_pos >= $signed(up_q)) && !sel_ge_up_q;
        ev[`EV_CONST_BEG] = spd_i == SPD_CONST && spd_q != SPD_CONST;
        ev[`EV_CONST_END] = spd_i != SPD_CONST && spd_q == SPD_CONST;
        ev[`EV_PULSE_DONE] = gen_busy_q && !gen_busy_i;
        if (ctrl_q[`CTRL_INTERP]) begin
            ev = 7'h00;
        end
        ctrl_d = ctrl_q;
        en_d   = en_q;
        up_d   = up_q;
        lo_d   = lo_q;
        jcnt_d = jcnt_q;
        stat_d = stat_q;
        if (wr && wb_adr_i == `OFS_CLEAR) begin
            stat_d = stat_q & ~wb_dat_i[6:0];
        end
        stat_d = stat_d | ev; // Set wins over a same-cycle clear.
        if (wr) begin
            case (wb_adr_i)
                `OFS_CTRL:      ctrl_d = merge(ctrl_q, wb_dat_i, wb_sel_i);
                `OFS_ENABLE:    en_d   = merge(en_q, wb_dat_i, wb_sel_i);
                `OFS_COMP_UP:   up_d   = merge(up_q, wb_dat_i, wb_sel_i);
                `OFS_COMP_LO:   lo_d   = merge(lo_q, wb_dat_i, wb_sel_i);
                `OFS_JOG_CNT:   jcnt_d = merge(jcnt_q, wb_dat_i, wb_sel_i);
                `OFS_CMD_POS:   cmd_d  = merge(cmd_q, wb_dat_i, wb_sel_i);
                `OFS_ACT_POS:   act_d  = merge(act_q, wb_dat_i, wb_sel_i);
                default:        ctrl_d = ctrl_q;
            endcase
        end
        case (wb_adr_i)
            `OFS_CTRL:     rdat_d = ctrl_q;
            `OFS_STATUS:   rdat_d = {25'h0, stat_q};
            `OFS_ENABLE:   rdat_d = en_q;
            `OFS_CMD_POS:  rdat_d = cmd_q;
            `OFS_ACT_POS:  rdat_d = act_q;
            `OFS_COMP_UP:  rdat_d = up_q;
            `OFS_COMP_LO:  rdat_d = lo_q;
            `OFS_JOG_CNT:  rdat_d = jcnt_q;
            `OFS_PIN_STAT: rdat_d = {27'h0, enc_i, jog_i};
            default:       rdat_d = 32'h0;
        endcase
        if (!rd_go || wb_we_i) begin
            rdat_d = 32'h0;
        end
        ack_d = rd_go;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q      <= `CTRL_RESET;
            en_q        <= 32'h0;
            up_q        <= `UP_RESET;
            lo_q        <= `LO_RESET;
            jcnt_q      <= `JOG_CNT_RESET;
            stat_q      <= 7'h00;
            cmd_q       <= 32'sh0;
            act_q       <= 32'sh0;
            wb_dat_o    <= 32'h0;
            wb_ack_o    <= 1'b0;
            js_q        <= JOG_IDLE;
            left_q      <= 32'h0;
            tick_q      <= 16'h0000;
            jp_q        <= 1'b0;
            jm_q        <= 1'b0;
            jdir_q      <= 1'b1;
            pulse_o     <= 1'b0;
            dir_o       <= 1'b1;
            lim_plus_o  <= 1'b0;
            lim_minus_o <= 1'b0;
            irq_o       <= 1'b0;
            gen_busy_q  <= 1'b0;
            sel_ge_lo_q <= 1'b0;
            sel_ge_up_q <= 1'b0;
            spd_q       <= SPD_IDLE;
        end else begin
            ctrl_q      <= ctrl_d;
            en_q        <= en_d;
            up_q        <= up_d;
            lo_q        <= lo_d;
            jcnt_q      <= jcnt_d;
            stat_q      <= stat_d;
            cmd_q       <= cmd_d;
            act_q       <= act_d;
            wb_dat_o    <= rdat_d;
            wb_ack_o    <= ack_d;
            js_q        <= js_d;
            left_q      <= left_d;
            tick_q      <= tick_d;
            jp_q        <= jog_i.plus;
            jm_q        <= jog_i.minus;
            jdir_q      <= jdir_d;
            pulse_o     <= pulse_d;
            dir_o       <= pdir_d;
            lim_plus_o  <= lim_p;
            lim_minus_o <= lim_m;
            irq_o       <= |(stat_d & en_d[6:0]);
            gen_busy_q  <= gen_busy_i;
            sel_ge_lo_q <= sel_pos >= $signed(lo_q);
            sel_ge_up_q <= sel_pos >= $signed(up_q);
            spd_q       <= spd_i;
        end
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    AST_CMD_COUNT: assert property (@(posedge clk_i) disable iff (rst_i)
        (pulse_o && !(wr && wb_adr_i == `OFS_CMD_POS))
        |=> cmd_q == $past(cmd_q) + ($past(dir_o) ? 32'sd1 : -32'sd1))
        else $error("command counter did not follow the pulse");
    AST_ACT_COUNT: assert property (@(posedge clk_i) disable iff (rst_i)
        (enc_step && !(wr && wb_adr_i == `OFS_ACT_POS))
        |=> act_q == $past(act_q) + ($past(enc_dir) ? 32'sd1 : -32'sd1))
        else $error("actual counter did not follow the encoder");
    AST_SOFT_LIMIT: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (gen_pulse_i && gen_dir_i && lim_p) |=> !pulse_o || !dir_o)
        else $error("pulse issued past the upper soft limit");
    AST_GE_LO: assert property (@(posedge clk_i) disable iff (rst_i)
        (ev[`EV_GE_LO]) |=> stat_q[`EV_GE_LO])
        else $error("lower bound reach not latched");
    AST_LT_LO: assert property (@(posedge clk_i) disable iff (rst_i)
        (ev[`EV_LT_LO]) |=> stat_q[`EV_LT_LO])
        else $error("below lower bound not latched");
    AST_LT_UP: assert property (@(posedge clk_i) disable iff (rst_i)
        (ev[`EV_LT_UP]) |=> stat_q[`EV_LT_UP])
        else $error("below upper bound not latched");
    AST_GE_UP: assert property (@(posedge clk_i) disable iff (rst_i)
        (ev[`EV_GE_UP]) |=> stat_q[`EV_GE_UP])
        else $error("upper bound reach not latched");
    AST_DONE: assert property (@(posedge clk_i) disable iff (rst_i)
        ($fell(gen_busy_i) && !ctrl_q[`CTRL_INTERP])
        |=> stat_q[`EV_PULSE_DONE])
        else $error("pulse finish not latched");
    AST_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o == |(stat_q & en_q[6:0]))
        else $error("interrupt does not match enabled status");
    AST_FIXED: assert property (@(posedge clk_i) disable iff (rst_i)
        (js_q == JOG_RUN && ctrl_q[`CTRL_JOG_FIXED] && left_q == 32'h0)
        |=> !pulse_o || $past(gen_pulse_i))
        else $error("fixed jog exceeded preset count");
    COV_IRQ:  cover property (@(posedge clk_i) $rose(irq_o));
    COV_JOG:  cover property (@(posedge clk_i) js_q == JOG_WAIT);
    COV_LIM:  cover property (@(posedge clk_i) lim_p);
endmodule

// ===== pkg/axis_cmp_defs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef AXIS_CMP_DEFS_SVH
`define AXIS_CMP_DEFS_SVH
`define OFS_CTRL      8'h00
`define OFS_STATUS    8'h04
`define OFS_CLEAR     8'h08
`define OFS_ENABLE    8'h0c
`define OFS_CMD_POS   8'h10
`define OFS_ACT_POS   8'h14
`define OFS_COMP_UP   8'h18
`define OFS_COMP_LO   8'h1c
`define OFS_JOG_CNT   8'h20
`define OFS_PULSE_REQ 8'h24
`define OFS_PIN_STAT  8'h28
`define CTRL_ENC_MODE  0
`define CTRL_MULT_LSB  1
`define CTRL_JOG_EN    3
`define CTRL_JOG_FIXED 4
`define CTRL_HANDWHEEL 5
`define CTRL_SWLIM_EN  6
`define CTRL_CMP_SEL   7
`define CTRL_INTERP    8
`define CTRL_RESET     32'h0000_0000
`define EV_GE_LO       0
`define EV_LT_LO       1
`define EV_LT_UP       2
`define EV_GE_UP       3
`define EV_CONST_BEG   4
`define EV_CONST_END   5
`define EV_PULSE_DONE  6
`define JOG_CNT_RESET  32'h0000_0001
`define UP_RESET       32'h7fff_ffff
`define LO_RESET       32'h8000_0000
`define PULSE_PERIOD_NS 1000
`endif

// ===== pkg/axis_cmp_pkg.sv
// Types shared by the axis position and compare unit.
package axis_cmp_pkg;
    typedef enum logic [1:0] {MULT_X1, MULT_X2, MULT_X4, MULT_RSV} mult_e;
    typedef struct packed {
        logic a;
        logic b;
        logic index;
    } enc_pins_s;
    typedef struct packed {
        logic plus;
        logic minus;
    } jog_pins_s;
    typedef enum logic [1:0] {SPD_IDLE, SPD_ACCEL, SPD_CONST, SPD_DECEL} spd_e;
    typedef enum logic [1:0] {JOG_IDLE, JOG_RUN, JOG_WAIT} jog_state_e;
endpackage

// ===== hdl/enc_decoder.sv
// Encoder decoder: quadrature x1/x2/x4 or up/down pulse counting.
`timescale 1ns/1ps
module enc_decoder (
    input  wire logic                  clk_i,  // System clock
    input  wire logic                  rst_i,  // Sync reset
    input  wire logic                  updn_i, // 1: up/down pulse pair
    input  wire axis_cmp_pkg::mult_e   mult_i, // Quadrature multiplier
    input  wire axis_cmp_pkg::enc_pins_s pins_i, // Encoder pins
    output logic                       step_o, // One count pulse
    output logic                       dir_o   // 1: count up
);
    import axis_cmp_pkg::*;

    logic a_q, b_q, a_d, b_d;
    logic step_d, dir_d;
    logic a_ed, b_ed;

    // --------------------------------------------------------------
    // Edge decode
    // --------------------------------------------------------------
    always_comb begin
        a_d    = pins_i.a;
        b_d    = pins_i.b;
        a_ed   = a_q ^ pins_i.a;
        b_ed   = b_q ^ pins_i.b;
        step_d = 1'b0;
        dir_d  = 1'b1;
        if (updn_i) begin
            // Up on a rising, down on b rising; both at once cancel.
            if ((pins_i.a & ~a_q) ^ (pins_i.b & ~b_q)) begin
                step_d = 1'b1;
                dir_d  = pins_i.a & ~a_q;
            end
        end else begin
            case (mult_i)
                MULT_X1: begin
                    if (a_ed && pins_i.a) begin
                        step_d = 1'b1;
                        dir_d  = ~pins_i.b;
                    end
                end
                MULT_X2: begin
                    if (a_ed && !b_ed) begin
                        step_d = 1'b1;
                        dir_d  = pins_i.a ^ pins_i.b;
                    end
                end
                MULT_X4: begin
                    if (a_ed ^ b_ed) begin
                        step_d = 1'b1;
                        dir_d  = a_ed ? (pins_i.a ^ pins_i.b)
                                      : ~(pins_i.a ^ pins_i.b);
                    end
                end
                default: step_d = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a_q    <= 1'b0;
            b_q    <= 1'b0;
            step_o <= 1'b0;
            dir_o  <= 1'b1;
        end else begin
            a_q    <= a_d;
            b_q    <= b_d;
            step_o <= step_d;
            dir_o  <= dir_d;
        end
    end

    AST_ENC_X1_STEP: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (step_o && !$past(updn_i) && $past(mult_i) == MULT_X1)
        |-> $rose(a_q))
        else $error("x1 count fired on a wrong edge");
endmodule

// ===== tb/enc_jog_model.sv
// Encoder and jog switch model that drives the unit's pin inputs.
`timescale 1ns/1ps
module enc_jog_model (
    input  wire logic               clk_i, // System clock
    output axis_cmp_pkg::enc_pins_s enc_o, // Encoder pins
    output axis_cmp_pkg::jog_pins_s jog_o  // Jog switch pins
);
    import axis_cmp_pkg::*;
    logic [1:0] ph;
    initial begin
        ph = 2'h0;
        enc_o = '0;
        jog_o = '0;
    end
    // -----------------------------------------------------------------
    // Pin stimulus
    // -----------------------------------------------------------------
    // Gray order changes one phase per step; 350 ns clears the A/B gap.
    task automatic quad(input int n, input logic up);
        for (int i = 0; i < 4 * n; i++) begin
            @(posedge clk_i);
            ph = up ? ph + 2'h1 : ph - 2'h1;
            enc_o <= '{a: ph[0] ^ ph[1], b: ph[1], index: 1'b0};
            repeat (6) @(posedge clk_i);
        end
    endtask
    // Up pulses on phase A, down pulses on phase B, 200 ns each way.
    task automatic updn(input int n, input logic up);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            enc_o <= '{a: up, b: !up, index: 1'b0};
            repeat (4) @(posedge clk_i);
            enc_o <= '0;
            repeat (4) @(posedge clk_i);
        end
    endtask
    // Switches are pulled low, so a released button reads 0.
    task automatic press(input logic plus, input int cyc);
        @(posedge clk_i);
        jog_o <= '{plus: plus, minus: !plus};
        repeat (cyc) @(posedge clk_i);
        jog_o <= '0;
        repeat (10) @(posedge clk_i);
    endtask
endmodule

// ===== tb/axis_position_compare_unit_tb_top.sv
// Self-checking testbench for the axis position and compare unit.
`timescale 1ns/1ps
`include "axis_cmp_defs.svh"
module axis_position_compare_unit_tb_top;
    import axis_cmp_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        req = 1'b0, we = 1'b0, gp = 1'b0, gd = 1'b0, busy = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic        ack, pulse, dir, limp, limm, irq;
    spd_e        spd = SPD_IDLE;
    enc_pins_s   enc;
    jog_pins_s   jog;
    int          err_total = 0, checks = 0, cycles = 0, pulses = 0, p0, d;

    always #25 clk_i = ~clk_i;

    enc_jog_model model (.clk_i(clk_i), .enc_o(enc), .jog_o(jog));

    axis_position_compare_unit DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .enc_i(enc), .jog_i(jog),
        .spd_i(spd), .gen_pulse_i(gp), .gen_dir_i(gd), .gen_busy_i(busy),
        .pulse_o(pulse), .dir_o(dir), .lim_plus_o(limp),
        .lim_minus_o(limm), .irq_o(irq));

    always @(posedge clk_i) begin
        if (pulse === 1'b1)
            pulses <= pulses + 1;
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_total++;
            final_report();
        end
    end
    // -----------------------------------------------------------------
    // Bus and compare tasks
    // -----------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        cmp32({31'h0, got}, {31'h0, exp});
    endtask
    // Request held from launch edge until the edge that samples ack.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] dv);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= dv;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 40);
        q = rdat;
        cmp1(ack, 1'b1);
        req <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dv);
        xfer(1'b1, a, dv);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        cmp32(q, exp);
    endtask
    task automatic gen(input int n, input logic up);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            gp <= 1'b1;
            gd <= up;
            @(posedge clk_i);
            gp <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
    endtask
    // -----------------------------------------------------------------
    // Test sequence
    // -----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        cmp1(dir, 1'b1);
        rd(`OFS_CTRL, `CTRL_RESET);
        rd(`OFS_COMP_UP, `UP_RESET);
        rd(`OFS_COMP_LO, `LO_RESET);
        rd(`OFS_JOG_CNT, `JOG_CNT_RESET);
        rd(`OFS_CMD_POS, 32'h0);
        rd(8'h3c, 32'h0);
        for (int m = 0; m < 3; m++) begin
            wr(`OFS_CTRL, 32'(m) << `CTRL_MULT_LSB);
            wr(`OFS_ACT_POS, 32'h0);
            model.quad(3, 1'b1);
            model.quad(1, 1'b0);
            rd(`OFS_ACT_POS, 32'(2 << m));
            model.quad(3, 1'b0);
            rd(`OFS_ACT_POS, -32'(1 << m));
        end
        wr(`OFS_CTRL, 32'h1);
        wr(`OFS_ACT_POS, 32'h0);
        model.updn(3, 1'b1);
        model.updn(5, 1'b0);
        rd(`OFS_ACT_POS, -32'h2);
        wr(`OFS_CTRL, 32'h0);
        wr(`OFS_COMP_LO, 32'h5);
        wr(`OFS_COMP_UP, 32'ha);
        wr(`OFS_CMD_POS, 32'h0);
        wr(`OFS_CLEAR, 32'h7f);
        rd(`OFS_STATUS, 32'h0);
        wr(`OFS_CMD_POS, 32'h7);
        rd(`OFS_STATUS, 32'h1);
        wr(`OFS_CMD_POS, 32'hc);
        rd(`OFS_STATUS, 32'h9);
        wr(`OFS_CMD_POS, 32'h3);
        rd(`OFS_STATUS, 32'hf);
        cmp1(irq, 1'b0);
        wr(`OFS_ENABLE, 32'h2);
        cmp1(irq, 1'b1);
        wr(`OFS_CLEAR, 32'h2);
        rd(`OFS_STATUS, 32'hd);
        cmp1(irq, 1'b0);
        wr(`OFS_CLEAR, 32'h7f);
        wr(`OFS_CTRL, 32'h100);
        wr(`OFS_CMD_POS, 32'hc);
        wr(`OFS_CMD_POS, 32'h3);
        rd(`OFS_STATUS, 32'h0);
        wr(`OFS_CTRL, 32'h40);
        wr(`OFS_CMD_POS, 32'hc);
        cmp1(limp, 1'b1);
        p0 = pulses;
        gen(2, 1'b1);
        rd(`OFS_CMD_POS, 32'hc);
        gen(8, 1'b0);
        cmp1(dir, 1'b0);
        gen(2, 1'b0);
        rd(`OFS_CMD_POS, 32'h4);
        cmp32(32'(pulses - p0), 32'h8);
        cmp1(limm, 1'b1);
        wr(`OFS_CTRL, 32'h0);
        wr(`OFS_ENABLE, 32'h70);
        wr(`OFS_CLEAR, 32'h7f);
        @(posedge clk_i);
        spd <= SPD_ACCEL;
        busy <= 1'b1;
        repeat (5) @(posedge clk_i);
        spd <= SPD_CONST;
        repeat (5) @(posedge clk_i);
        spd <= SPD_DECEL;
        repeat (5) @(posedge clk_i);
        spd <= SPD_IDLE;
        busy <= 1'b0;
        repeat (5) @(posedge clk_i);
        rd(`OFS_STATUS, 32'h70);
        cmp1(irq, 1'b1);
        wr(`OFS_CLEAR, 32'h70);
        cmp1(irq, 1'b0);
        wr(`OFS_CTRL, 32'h18);
        wr(`OFS_JOG_CNT, 32'h3);
        wr(`OFS_CMD_POS, 32'h0);
        p0 = pulses;
        model.press(1'b1, 200);
        rd(`OFS_CMD_POS, 32'h3);
        cmp32(32'(pulses - p0), 32'h3);
        wr(`OFS_CTRL, 32'h8);
        p0 = pulses;
        model.press(1'b0, 100);
        d = pulses - p0;
        cmp1(d >= 4 && d <= 6, 1'b1);
        rd(`OFS_CMD_POS, 32'(3 - d));
        wr(`OFS_CTRL, 32'h28);
        wr(`OFS_CMD_POS, 32'h0);
        for (int i = 0; i < 6; i++)
            model.press(i < 4, 10);
        rd(`OFS_CMD_POS, 32'h2);
        wr(`OFS_CTRL, 32'h80);
        wr(`OFS_CLEAR, 32'h7f);
        wr(`OFS_ACT_POS, 32'h7);
        rd(`OFS_STATUS, 32'h1);
        final_report();
    end
endmodule
